/* File: common/sci_consts.svh */
// shared constants of the sine/cosine interpolator link
`ifndef SCI_CONSTS_SVH
`define SCI_CONSTS_SVH
// clocking
`define SCI_CLK_PERIOD_PS 4000
`define SCI_CLK_RATE_KHZ 250000
`define SCI_ADC_RATE_KHZ 20000
`define SCI_HALF_MIN_PS 40000
`define SCI_DIV_MIN 3'h3
`define SCI_DIV_RST 3'h5
`define SCI_DLY_UNIT 4'h0
`define SCI_FRAME_LAST 5'h18
`define SCI_ATAN_LAST 4'hb
`define SCI_HALF_TURN 12'h800
// widths
`define SCI_WORD_W 24
`define SCI_VAL_W 12
`define SCI_SUB_W 12
`define SCI_CAP_W 32
`define SCI_AXI_AW 8
// decode and mode
`define SCI_DEC_X4_UP 3'h7
`define SCI_DEC_X4_DN 3'h3
`define SCI_MODE_RST 24'h800000
`define SCI_START_BIT 23
`define SCI_WP_UNLOCK 32'haaaaaaaa
`define SCI_FIFO_DEPTH 2'h2
// bus answers
`define SCI_RESP_OKAY 2'h0
`define SCI_RESP_SLVERR 2'h2
// register offsets
`define SCI_REG_KEY 8'h00
`define SCI_REG_CTRL 8'h04
`define SCI_REG_CLK 8'h08
`define SCI_REG_OFFS 8'h0c
`define SCI_REG_MODE 8'h10
`define SCI_REG_SUB 8'h14
`define SCI_REG_PCAP 8'h18
`define SCI_REG_SCAP 8'h1c
`define SCI_REG_VAL 8'h20
// register fields
`define SCI_CTRL_MERGE 0
`define SCI_CTRL_DEC 6:4
`define SCI_CLK_SAMP 2:0
`define SCI_CLK_CONV 6:4
`define SCI_CLK_DLY 15:8
`define SCI_OFF_SIN 11:0
`define SCI_OFF_COS 27:16
`define SCI_MODE_FLD 23:0
`define SCI_SUB_FLD 11:0
`define SCI_VAL_FLD 23:0
`endif

/* File: common/sci_link_if.sv */
// serial converter and quadrature link between the two ends
`timescale 1ns/10ps
interface sci_link_if;
  logic conv_sclk;
  logic mode_bit;
  logic conv_data;
  logic quad_a;
  logic quad_b;
  modport asic (output conv_sclk, output mode_bit, input conv_data, input quad_a, input quad_b);
  modport fpga (input conv_sclk, input mode_bit, output conv_data, output quad_a, output quad_b);
endinterface

/* File: common/sci_pkg.sv */
// types of the sine/cosine interpolator link
`include "sci_consts.svh"
package sci_pkg;
  typedef enum logic [2:0] {
    SCI_DS_IDLE = 3'h1,
    SCI_DS_XFER = 3'h2,
    SCI_DS_ATAN = 3'h4
  } sci_dev_st_t;

  typedef struct packed {
    sci_dev_st_t st;
    logic aw_held;
    logic [`SCI_AXI_AW-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] wp_key;
    logic merge_en;
    logic [2:0] decode;
    logic [2:0] samp_div;
    logic [2:0] conv_div;
    logic [7:0] dly_set;
    logic [`SCI_VAL_W-1:0] off_sin;
    logic [`SCI_VAL_W-1:0] off_cos;
    logic [`SCI_WORD_W-1:0] mode_word;
    logic [1:0] phase_sy;
    logic [1:0] servo_sy;
    logic phase_d;
    logic servo_d;
    logic [7:0] conv_cnt;
    logic conv_ph;
    logic [8:0] samp_cnt;
    logic qa_d;
    logic qb_d;
    logic [`SCI_CAP_W-1:0] count;
    logic armed;
    logic [11:0] dly_cnt;
    logic pend;
    logic [`SCI_CAP_W-1:0] lat_count;
    logic sclk;
    logic mode_bit;
    logic [4:0] idx;
    logic [`SCI_WORD_W-1:0] mode_sh;
    logic [`SCI_WORD_W:0] rx_sh;
    logic [3:0] iter;
    logic [15:0] cx;
    logic [15:0] cy;
    logic [`SCI_SUB_W-1:0] cz;
    logic [`SCI_SUB_W-1:0] sub_count;
    logic [`SCI_WORD_W-1:0] conv_val;
    logic [`SCI_CAP_W-1:0] phase_cap;
    logic [`SCI_CAP_W-1:0] servo_cap;
  } sci_dev_state_t;

  typedef struct packed {
    logic [17:0] acc;
    logic tick;
    logic [1:0][`SCI_WORD_W-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] used;
    logic [`SCI_WORD_W-1:0] last;
    logic sclk_d;
    logic [4:0] idx;
    logic started;
    logic [`SCI_WORD_W-1:0] mode_sh;
    logic [`SCI_WORD_W-1:0] tx_sh;
    logic data_bit;
    logic [`SCI_WORD_W-1:0] mode_out;
    logic mode_valid;
    logic qa;
    logic qb;
  } sci_fpga_state_t;
endpackage

/* File: verif/sci_link_chk.sv */
// link checker: frame shape and quadrature pacing
`timescale 1ns/10ps
module sci_link_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // link
  input wire logic conv_sclk,
  input wire logic mode_bit,
  input wire logic conv_data,
  input wire logic quad_a,
  input wire logic quad_b
);
  logic [4:0] rises_ff;
  logic [8:0] hi_ff;
  logic [8:0] lo_ff;
  logic start_ff;
  logic [4:0] cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // long low time ends a frame
  assign cnt = (lo_ff > 9'd200) ? 5'd0 : rises_ff;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rises_ff <= 5'd0;
      hi_ff <= 9'd0;
      lo_ff <= 9'd0;
      start_ff <= 1'b0;
    end else begin
      hi_ff <= conv_sclk ? hi_ff + 9'd1 : 9'd0;
      lo_ff <= conv_sclk ? 9'd0 : (&lo_ff ? lo_ff : lo_ff + 9'd1);
      rises_ff <= $rose(conv_sclk) ? cnt + 5'd1 : cnt;
      if ($rose(conv_sclk) && cnt == 5'd0) begin
        start_ff <= mode_bit;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  sequence s_hi_half;
    conv_sclk [*8];
  endsequence
  sequence s_lo_half;
    !conv_sclk [*8];
  endsequence
  sequence s_quad_quiet;
    ($stable(quad_a) && $stable(quad_b)) [*8];
  endsequence
  a_sclk_high_min: assert property (
    $rose(conv_sclk) |=> s_hi_half) else $error("clock high half short");
  a_sclk_low_min: assert property (
    $fell(conv_sclk) |=> s_lo_half) else $error("clock low half short");
  a_half_legal: assert property (
    $fell(conv_sclk) |-> hi_ff inside {9'd10, 9'd20, 9'd40, 9'd80, 9'd160}) else $error("bad half length");
  a_frame_rises: assert property (
    lo_ff == 9'd200 |-> rises_ff == 5'd0 || rises_ff == 5'd25) else $error("frame rise count wrong");
  a_header_zero: assert property (
    $rose(conv_sclk) && cnt == 5'd0 |-> !conv_data) else $error("header bit not zero");
  a_mode_tail: assert property (
    $rose(conv_sclk) && cnt == 5'd24 |-> !mode_bit) else $error("mode bit after word");
  a_no_start: assert property (
    cnt != 5'd0 && !start_ff |-> !conv_data) else $error("data without start bit");
  a_data_low: assert property (
    $changed(conv_data) |-> !conv_sclk) else $error("data moved in high half");
  a_mode_low: assert property (
    $changed(mode_bit) |-> !conv_sclk) else $error("mode moved in high half");
  a_quad_single: assert property (
    !($changed(quad_a) && $changed(quad_b))) else $error("two quadrature edges");
  a_quad_spacing: assert property (
    $changed(quad_a) || $changed(quad_b) |=> s_quad_quiet) else $error("quadrature edges too close");
endmodule

/* File: verif/sincos_encoder_interpolator_asic_tb_top.sv */
// bench top: both ends joined, register, frame and capture tests
`timescale 1ns/10ps
`include "sci_consts.svh"
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module sincos_encoder_interpolator_asic_tb_top
  import sci_pkg::*;
;
  localparam logic [1:0] OK = `SCI_RESP_OKAY;
  localparam logic [1:0] ER = `SCI_RESP_SLVERR;
  logic clk_sys, reset_n, phase_clk, servo_clk, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sv, sr, stick, a_in, b_in, mvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [1:0] bresp, rresp, rr;
  logic [11:0] s_sin, s_cos;
  logic [23:0] mword;
  int n_fail, samples_checked, nrise, nmv, d0, nst;
  longint t_start, t_first, t_prev, t_last;
  int sin_t[3] = '{200, 300, 300};
  int cos_t[3] = '{300, 200, 200};
  sci_link_if link();
  sci_asic_end i_sci_asic_end (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .phase_clk(phase_clk),
    .servo_clk(servo_clk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link));
  sci_fpga_end i_sci_fpga_end (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .link(link),
    .sample_tick(stick), .sample_valid(sv), .sample_ready(sr), .sample_sin(s_sin), .sample_cos(s_cos),
    .quad_a_in(a_in), .quad_b_in(b_in), .mode_word(mword), .mode_valid(mvalid));
  sci_link_chk i_sci_link_chk (.clk_sys(clk_sys), .reset_n(reset_n), .conv_sclk(link.conv_sclk),
    .mode_bit(link.mode_bit), .conv_data(link.conv_data), .quad_a(link.quad_a), .quad_b(link.quad_b));
  ////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge link.conv_sclk) begin
    if (nrise == 0) begin
      t_first = $time;
    end
    t_prev = t_last;
    t_last = $time;
    nrise++;
  end
  always @(negedge clk_sys) begin
    if (mvalid === 1'b1) begin
      nmv++;
    end
    if (stick === 1'b1) begin
      nst++;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic tout(inout int k);
    k++;
    if (k > 300) begin
      $display("timeout at %0t", $time);
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int k;
    logic ta, tw, hb;
    k = 0;
    hb = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!hb) begin
      @(negedge clk_sys);
      ta = awready;
      tw = wready;
      hb = bvalid;
      if (hb) `CHK(bresp, e)
      @(posedge clk_sys);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
      tout(k);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    logic ta, hr;
    k = 0;
    hr = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!hr) begin
      @(negedge clk_sys);
      ta = arready;
      hr = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge clk_sys);
      if (ta) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
      tout(k);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(rv, e)
    `CHK(rr, OK)
  endtask
  task automatic push(input logic [11:0] s, input logic [11:0] c);
    int k;
    logic t;
    k = 0;
    t = 1'b0;
    @(posedge clk_sys);
    sv <= 1'b1;
    s_sin <= s;
    s_cos <= c;
    while (!t) begin
      @(negedge clk_sys);
      t = sr;
      @(posedge clk_sys);
      tout(k);
    end
    sv <= 1'b0;
  endtask
  task automatic pcyc(input int hi);
    nrise = 0;
    nmv = 0;
    nst = 0;
    t_start = $time;
    {phase_clk, servo_clk} <= 2'h3;
    repeat (hi) @(posedge clk_sys);
    {phase_clk, servo_clk} <= 2'h0;
    repeat (hi) @(posedge clk_sys);
    `CHK(nrise, 25)
    `CHK(nmv, 1)
    `CHK(nst * 25 - 4 * hi inside {[-25:25]}, 1'b1)
  endtask
  task automatic qseq;
    for (int i = 0; i < 4; i++) begin
      a_in <= (i < 2);
      b_in <= (i == 1 || i == 2);
      repeat (200) @(posedge clk_sys);
    end
  endtask
  function automatic logic near(input logic [11:0] g, input int s, input int c);
    int e;
    e = (int'($atan2(s, c) * 4096.0 / 6.283185307) + 8192 - int'(g)) % 4096;
    return e <= 2 || e >= 4094;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    {reset_n, phase_clk, servo_clk, awvalid, wvalid, bready, arvalid, rready, sv, a_in, b_in} <= '0;
    {awaddr, araddr, wdata, s_sin, s_cos} <= '0;
    n_fail = 0;
    samples_checked = 0;
    nrise = 0;
    nmv = 0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rdc(`SCI_REG_KEY, 32'h0);
    rdc(`SCI_REG_CTRL, 32'h70);
    rdc(`SCI_REG_CLK, 32'h55);
    rdc(`SCI_REG_MODE, 32'h800000);
    rd(8'h24);
    `CHK(rr, ER)
    wr(`SCI_REG_CTRL, 32'h71, ER);
    rdc(`SCI_REG_CTRL, 32'h70);
    wr(`SCI_REG_KEY, `SCI_WP_UNLOCK, OK);
    wr(`SCI_REG_OFFS, 32'h64, OK);
    wr(`SCI_REG_SUB, 32'h1, ER);
    $display("test reset and protect done");
    push(12'd200, 12'd300);
    push(12'd300, 12'd200);
    @(negedge clk_sys);
    `CHK(sr, 1'b0)
    @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      wr(`SCI_REG_CLK, 32'(5 | ((5 - i) << 4)), OK);
      pcyc(30 * (80 >> i));
      `CHK(t_last - t_prev, longint'(320 >> i))
      rdc(`SCI_REG_VAL, {8'h0, 12'(sin_t[i]), 12'(cos_t[i])});
      rd(`SCI_REG_SUB);
      `CHK(near(rv[11:0], sin_t[i] + 100, cos_t[i]), 1'b1)
      `CHK(mword, 24'h800000)
    end
    d0 = int'(t_first - t_start);
    `CHK(d0 inside {[60:140]}, 1'b1)
    $display("test frames and dividers done");
    qseq();
    pcyc(600);
    rdc(`SCI_REG_PCAP, 32'h4);
    rdc(`SCI_REG_SCAP, 32'h4);
    wr(`SCI_REG_CTRL, 32'h71, OK);
    pcyc(600);
    rd(`SCI_REG_PCAP);
    `CHK(rv[31:12], 20'h4)
    `CHK(near(rv[11:0], 400, 200), 1'b1)
    rd(`SCI_REG_SCAP);
    `CHK(rv[31:12], 20'h4)
    wr(`SCI_REG_CTRL, 32'h30, OK);
    qseq();
    pcyc(600);
    rdc(`SCI_REG_PCAP, 32'h0);
    $display("test captures done");
    wr(`SCI_REG_CLK, 32'h135, OK);
    pcyc(1200);
    `CHK(int'(t_first - t_start) inside {[1280:1400]}, 1'b1)
    wr(`SCI_REG_MODE, 32'h123456, OK);
    pcyc(1200);
    rdc(`SCI_REG_VAL, 32'h0);
    `CHK(mword, 24'h123456)
    $display("test delay and mode done");
    tally_and_finish();
  end
endmodule

/* File: verilog/sci_asic_end.sv */
// servo device end: setup registers, link master, decoder, arctangent, captures
`timescale 1ns/10ps
`include "sci_consts.svh"
// Summary of operation
// RULE_01 - add bias offsets to sine and cosine
// RULE_02 - sub-count always computed and readable
// RULE_03 - enable set: merged value latched at each phase and servo clock fall
// RULE_04 - sub-count in low twelve capture bits
// RULE_05 - enable clear: plain quadrature count latched
// RULE_06 - setup writes need unlock key pattern
// RULE_07 - far end samples converters at 20 MHz
// RULE_08 - quadrature sampled by encoder sample clock
// RULE_09 - at most one quadrature edge per sample
// RULE_10 - sample clock divider, default five, halving
// RULE_11 - converter clock divider: five, four, three
// RULE_12 - each serial transfer takes 25 clocks
// RULE_13 - strobe at phase rise, done by fall
// RULE_14 - strobe delayed by setting times sixteen clocks
// RULE_15 - far end sends corrected converter values
// RULE_16 - times-four decode for 3 or 7
// RULE_17 - 24-bit mode word out, msb first
// RULE_18 - delay counter restarts each phase rise
module sci_asic_end
  import sci_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // timing clocks
  input wire logic phase_clk,
  input wire logic servo_clk,
  // register bus
  input wire logic [`SCI_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SCI_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link
  sci_link_if.asic link
);
  localparam logic [`SCI_SUB_W-1:0] SCI_ATAN_TAB [0:11] = '{12'h200, 12'h12e, 12'h0a0, 12'h051,
    12'h029, 12'h014, 12'h00a, 12'h005, 12'h003, 12'h001, 12'h001, 12'h000};

  sci_dev_state_t s_ff;
  sci_dev_state_t nxt;
  logic [7:0] conv_half;
  logic [8:0] samp_per;
  logic conv_rise;
  logic conv_fall;
  logic samp_tick;
  logic ph_rise;
  logic ph_fall;
  logic sv_fall;
  logic up;
  logic [32:0] wr_cur;
  logic [32:0] rd_cur;
  logic [31:0] wv;
  logic [15:0] sin_b;
  logic [15:0] cos_b;
  logic signed [15:0] dx;
  logic signed [15:0] dy;
  logic [`SCI_CAP_W-1:0] cap_val;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] sci_half(input logic [2:0] div);
    logic [2:0] d;
    d = (div < `SCI_DIV_MIN) ? `SCI_DIV_MIN : div;
    return 8'((`SCI_HALF_MIN_PS / `SCI_CLK_PERIOD_PS) << (d - `SCI_DIV_MIN));
  endfunction

  function automatic logic [31:0] sci_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [32:0] sci_rd(input sci_dev_state_t s, input logic [`SCI_AXI_AW-1:0] a);
    logic [31:0] w;
    logic hit;
    w = 32'h0;
    hit = 1'h1;
    case (a)
      `SCI_REG_KEY: w = s.wp_key;
      `SCI_REG_CTRL: begin
        w[`SCI_CTRL_MERGE] = s.merge_en;
        w[`SCI_CTRL_DEC] = s.decode;
      end
      `SCI_REG_CLK: begin
        w[`SCI_CLK_SAMP] = s.samp_div;
        w[`SCI_CLK_CONV] = s.conv_div;
        w[`SCI_CLK_DLY] = s.dly_set;
      end
      `SCI_REG_OFFS: begin
        w[`SCI_OFF_SIN] = s.off_sin;
        w[`SCI_OFF_COS] = s.off_cos;
      end
      `SCI_REG_MODE: w[`SCI_MODE_FLD] = s.mode_word;
      `SCI_REG_SUB: w[`SCI_SUB_FLD] = s.sub_count;
      `SCI_REG_PCAP: w = s.phase_cap;
      `SCI_REG_SCAP: w = s.servo_cap;
      `SCI_REG_VAL: w[`SCI_VAL_FLD] = s.conv_val;
      default: hit = 1'h0;
    endcase
    return {hit, w};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt = s_ff;
    conv_half = sci_half(s_ff.conv_div); // RULE_11
    samp_per = {sci_half(s_ff.samp_div), 1'h0}; // RULE_10
    conv_rise = 1'h0;
    conv_fall = 1'h0;
    samp_tick = 1'h0;
    up = 1'h0;
    ph_rise = s_ff.phase_sy[1] & ~s_ff.phase_d;
    ph_fall = ~s_ff.phase_sy[1] & s_ff.phase_d;
    sv_fall = ~s_ff.servo_sy[1] & s_ff.servo_d;
    wr_cur = sci_rd(s_ff, s_ff.aw_addr);
    rd_cur = sci_rd(s_ff, s_axi_araddr);
    wv = sci_merge(wr_cur[31:0], s_ff.w_data, s_ff.w_strb);
    sin_b = {{4{s_ff.rx_sh[23]}}, s_ff.rx_sh[23:12]} + {{4{s_ff.off_sin[11]}}, s_ff.off_sin}; // RULE_01
    cos_b = {{4{s_ff.rx_sh[11]}}, s_ff.rx_sh[11:0]} + {{4{s_ff.off_cos[11]}}, s_ff.off_cos}; // RULE_01
    dx = $signed(s_ff.cx) >>> s_ff.iter;
    dy = $signed(s_ff.cy) >>> s_ff.iter;
    if (s_ff.merge_en) begin
      cap_val = {s_ff.lat_count[`SCI_CAP_W-`SCI_SUB_W-1:0], s_ff.sub_count}; // RULE_03 RULE_04
    end else begin
      cap_val = s_ff.lat_count; // RULE_05
    end
    // pin synchronisers
    nxt.phase_sy = {s_ff.phase_sy[0], phase_clk};
    nxt.servo_sy = {s_ff.servo_sy[0], servo_clk};
    nxt.phase_d = s_ff.phase_sy[1];
    nxt.servo_d = s_ff.servo_sy[1];
    // converter clock divider
    if (s_ff.conv_cnt >= conv_half - 8'h1) begin
      nxt.conv_cnt = 8'h0;
      nxt.conv_ph = ~s_ff.conv_ph;
      conv_rise = ~s_ff.conv_ph;
      conv_fall = s_ff.conv_ph;
    end else begin
      nxt.conv_cnt = s_ff.conv_cnt + 8'h1;
    end
    // sample clock divider
    if (s_ff.samp_cnt >= samp_per - 9'h1) begin
      nxt.samp_cnt = 9'h0;
      samp_tick = 1'h1;
    end else begin
      nxt.samp_cnt = s_ff.samp_cnt + 9'h1;
    end
    // quadrature decode
    if (samp_tick) begin // RULE_08
      nxt.qa_d = link.quad_a;
      nxt.qb_d = link.quad_b;
      if ((link.quad_a ^ s_ff.qa_d) != (link.quad_b ^ s_ff.qb_d)) begin // RULE_09
        up = link.quad_a ^ s_ff.qb_d;
        if (s_ff.decode == `SCI_DEC_X4_UP) begin // RULE_16
          nxt.count = up ? s_ff.count + 32'h1 : s_ff.count - 32'h1;
        end else if (s_ff.decode == `SCI_DEC_X4_DN) begin // RULE_16
          nxt.count = up ? s_ff.count - 32'h1 : s_ff.count + 32'h1;
        end
      end
    end
    // strobe delay
    if (ph_rise) begin
      nxt.armed = 1'h1; // RULE_18
      nxt.dly_cnt = 12'h0; // RULE_18
    end else if (s_ff.armed) begin
      if (s_ff.dly_cnt == {s_ff.dly_set, `SCI_DLY_UNIT}) begin // RULE_14
        nxt.armed = 1'h0;
        nxt.pend = 1'h1;
        nxt.lat_count = s_ff.count; // RULE_13
      end else if (conv_rise) begin
        nxt.dly_cnt = s_ff.dly_cnt + 12'h1;
      end
    end
    // transfer and arctangent
    case (s_ff.st)
      SCI_DS_IDLE: begin
        if (conv_fall && s_ff.pend) begin
          nxt.st = SCI_DS_XFER;
          nxt.pend = s_ff.armed & (s_ff.dly_cnt == {s_ff.dly_set, `SCI_DLY_UNIT}) & ~ph_rise;
          nxt.idx = 5'h0;
          nxt.mode_sh = s_ff.mode_word; // RULE_17
          nxt.mode_bit = s_ff.mode_word[`SCI_START_BIT]; // RULE_17
        end
      end
      SCI_DS_XFER: begin
        if (conv_rise) begin
          nxt.sclk = 1'h1;
          nxt.rx_sh = {s_ff.rx_sh[`SCI_WORD_W-1:0], link.conv_data};
        end
        if (conv_fall) begin
          nxt.sclk = 1'h0;
          if (s_ff.idx == `SCI_FRAME_LAST) begin // RULE_12
            nxt.st = SCI_DS_ATAN;
            nxt.mode_bit = 1'h0;
            nxt.conv_val = s_ff.rx_sh[`SCI_WORD_W-1:0];
            nxt.iter = 4'h0;
            nxt.cx = cos_b[15] ? 16'h0 - cos_b : cos_b;
            nxt.cy = cos_b[15] ? 16'h0 - sin_b : sin_b;
            nxt.cz = cos_b[15] ? `SCI_HALF_TURN : 12'h0;
          end else begin
            nxt.idx = s_ff.idx + 5'h1;
            nxt.mode_sh = {s_ff.mode_sh[`SCI_WORD_W-2:0], 1'h0};
            nxt.mode_bit = s_ff.mode_sh[`SCI_WORD_W-2]; // RULE_17
          end
        end
      end
      SCI_DS_ATAN: begin
        if (!s_ff.cy[15]) begin
          nxt.cx = s_ff.cx + dy;
          nxt.cy = s_ff.cy - dx;
          nxt.cz = s_ff.cz + SCI_ATAN_TAB[s_ff.iter];
        end else begin
          nxt.cx = s_ff.cx - dy;
          nxt.cy = s_ff.cy + dx;
          nxt.cz = s_ff.cz - SCI_ATAN_TAB[s_ff.iter];
        end
        nxt.iter = s_ff.iter + 4'h1;
        if (s_ff.iter == `SCI_ATAN_LAST) begin
          nxt.st = SCI_DS_IDLE;
          nxt.sub_count = nxt.cz; // RULE_02
        end
      end
      default: nxt.st = SCI_DS_IDLE;
    endcase
    // captures
    if (ph_fall) begin
      nxt.phase_cap = cap_val; // RULE_03 RULE_13
    end
    if (sv_fall) begin
      nxt.servo_cap = cap_val; // RULE_03
    end
    // register bus write
    if (s_ff.bvalid && s_axi_bready) begin
      nxt.bvalid = 1'h0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      nxt.aw_held = 1'h1;
      nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt.w_held = 1'h1;
      nxt.w_data = s_axi_wdata;
      nxt.w_strb = s_axi_wstrb;
    end
    if (s_ff.aw_held && s_ff.w_held) begin
      nxt.aw_held = 1'h0;
      nxt.w_held = 1'h0;
      nxt.bvalid = 1'h1;
      nxt.bresp = `SCI_RESP_OKAY;
      if (s_ff.aw_addr == `SCI_REG_KEY) begin
        nxt.wp_key = wv;
      end else if (s_ff.wp_key != `SCI_WP_UNLOCK) begin // RULE_06
        nxt.bresp = `SCI_RESP_SLVERR;
      end else begin
        case (s_ff.aw_addr)
          `SCI_REG_CTRL: begin
            nxt.merge_en = wv[`SCI_CTRL_MERGE];
            nxt.decode = wv[`SCI_CTRL_DEC];
          end
          `SCI_REG_CLK: begin
            nxt.samp_div = wv[`SCI_CLK_SAMP];
            nxt.conv_div = wv[`SCI_CLK_CONV];
            nxt.dly_set = wv[`SCI_CLK_DLY];
          end
          `SCI_REG_OFFS: begin
            nxt.off_sin = wv[`SCI_OFF_SIN];
            nxt.off_cos = wv[`SCI_OFF_COS];
          end
          `SCI_REG_MODE: nxt.mode_word = wv[`SCI_MODE_FLD];
          default: nxt.bresp = `SCI_RESP_SLVERR;
        endcase
      end
    end
    // register bus read
    if (s_ff.rvalid && s_axi_rready) begin
      nxt.rvalid = 1'h0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt.rvalid = 1'h1;
      nxt.rdata = rd_cur[31:0];
      nxt.rresp = rd_cur[32] ? `SCI_RESP_OKAY : `SCI_RESP_SLVERR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_ff <= '0;
      s_ff.st <= SCI_DS_IDLE;
      s_ff.decode <= `SCI_DEC_X4_UP;
      s_ff.samp_div <= `SCI_DIV_RST;
      s_ff.conv_div <= `SCI_DIV_RST;
      s_ff.mode_word <= `SCI_MODE_RST;
    end else if (clk_en) begin
      s_ff <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign s_axi_awready = ~s_ff.aw_held & ~s_ff.bvalid;
  assign s_axi_wready = ~s_ff.w_held & ~s_ff.bvalid;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = ~s_ff.rvalid;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign link.conv_sclk = s_ff.sclk;
  assign link.mode_bit = s_ff.mode_bit;
endmodule

/* File: verilog/sci_fpga_end.sv */
// interpolator end: sample buffer, serial converter link, quadrature out
`timescale 1ns/10ps
`include "sci_consts.svh"
module sci_fpga_end
  import sci_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // link
  sci_link_if.fpga link,
  // corrected samples
  output logic sample_tick,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [`SCI_VAL_W-1:0] sample_sin,
  input wire logic [`SCI_VAL_W-1:0] sample_cos,
  // synthesized quadrature
  input wire logic quad_a_in,
  input wire logic quad_b_in,
  // received mode word
  output logic [`SCI_WORD_W-1:0] mode_word,
  output logic mode_valid
);
  sci_fpga_state_t s_ff;
  sci_fpga_state_t nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic push;
  logic pop;
  logic [`SCI_WORD_W-1:0] head;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt = s_ff;
    sclk_rise = link.conv_sclk & ~s_ff.sclk_d;
    sclk_fall = ~link.conv_sclk & s_ff.sclk_d;
    push = sample_valid & sample_ready;
    pop = 1'h0;
    head = (s_ff.used != 2'h0) ? s_ff.mem[s_ff.rd_ptr] : s_ff.last;
    nxt.sclk_d = link.conv_sclk;
    nxt.mode_valid = 1'h0;
    nxt.tick = 1'h0;
    // fixed rate converter strobe
    if (s_ff.acc >= 18'(`SCI_CLK_RATE_KHZ - `SCI_ADC_RATE_KHZ)) begin // RULE_07
      nxt.acc = s_ff.acc - 18'(`SCI_CLK_RATE_KHZ - `SCI_ADC_RATE_KHZ);
      nxt.tick = 1'h1;
    end else begin
      nxt.acc = s_ff.acc + 18'(`SCI_ADC_RATE_KHZ);
    end
    // one quadrature edge per strobe
    if (s_ff.tick) begin
      if (s_ff.qa != quad_a_in) begin // RULE_09
        nxt.qa = quad_a_in; // RULE_08
      end else begin
        nxt.qb = quad_b_in;
      end
    end
    // serial frame
    if (sclk_rise) begin
      nxt.mode_sh = {s_ff.mode_sh[`SCI_WORD_W-2:0], link.mode_bit};
      if (s_ff.idx == 5'h0 && link.mode_bit) begin
        nxt.started = 1'h1;
        pop = (s_ff.used != 2'h0);
        nxt.tx_sh = head; // RULE_15
        nxt.last = head;
      end
      if (s_ff.idx == `SCI_FRAME_LAST) begin // RULE_12
        nxt.idx = 5'h0;
        nxt.started = 1'h0;
        nxt.mode_out = s_ff.mode_sh;
        nxt.mode_valid = 1'h1;
      end else begin
        nxt.idx = s_ff.idx + 5'h1;
      end
    end
    if (sclk_fall) begin
      nxt.data_bit = s_ff.started & s_ff.tx_sh[`SCI_WORD_W-1];
      if (s_ff.started) begin
        nxt.tx_sh = {s_ff.tx_sh[`SCI_WORD_W-2:0], 1'h0};
      end
    end
    // two-entry buffer
    if (pop) begin
      nxt.rd_ptr = ~s_ff.rd_ptr;
    end
    if (push) begin
      nxt.mem[s_ff.wr_ptr] = {sample_sin, sample_cos};
      nxt.wr_ptr = ~s_ff.wr_ptr;
    end
    case ({push, pop})
      2'h2: nxt.used = s_ff.used + 2'h1;
      2'h1: nxt.used = s_ff.used - 2'h1;
      default: nxt.used = s_ff.used;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_ff <= '0;
    end else if (clk_en) begin
      s_ff <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign sample_ready = (s_ff.used != `SCI_FIFO_DEPTH);
  assign sample_tick = s_ff.tick;
  assign mode_word = s_ff.mode_out;
  assign mode_valid = s_ff.mode_valid;
  assign link.conv_data = s_ff.data_bit;
  assign link.quad_a = s_ff.qa;
  assign link.quad_b = s_ff.qb;
endmodule
